//--- shared/rsc_pkg.sv
/*
  Constants and carrier types for the meter range, sampling and
  parameter entry control. Assumes a 25 MHz clock and front-panel
  keys delivered as one-cycle pulses.
*/
package rsc_pkg;
  localparam int CLK_MHZ    = 25;
  localparam int LINE50_US  = 20000;
  localparam int LINE60_US  = 16700;
  localparam int LINE50_CYC = LINE50_US * CLK_MHZ;
  localparam int LINE60_CYC = LINE60_US * CLK_MHZ;
  localparam logic [20:0] UP_6D  = 21'h124F80;
  localparam logic [20:0] DN_6D  = 21'h01869F;
  localparam logic [20:0] UP_5D  = 21'h01D4C0;
  localparam logic [20:0] DN_5D  = 21'h00270F;
  localparam logic [20:0] UP_4D  = 21'h002EE0;
  localparam logic [20:0] DN_4D  = 21'h0003E7;
  localparam logic [20:0] UP_TOP = 21'h07EF40;
  localparam logic [20:0] DN_TOP = 21'h00C34F;
  localparam logic [2:0] RANGE_LOW      = 3'h0;
  localparam logic [2:0] RANGE_LAST_DCV = 3'h3;
  localparam logic [2:0] RANGE_LAST_OTH = 3'h4;
  localparam logic [2:0] INT_ONE  = 3'h0;
  localparam logic [2:0] INT_LAST = 3'h5;
  localparam logic [1:0] DIG_6 = 2'h0;
  localparam logic [1:0] DIG_5 = 2'h1;
  localparam logic [1:0] DIG_4 = 2'h2;
  localparam logic [11:0] BUZ_LAST = 12'h002;
  localparam logic [11:0] ANA_LAST = 12'h004;
  localparam logic [11:0] RES_LAST = 12'h002;
  localparam logic [1:0] CUR_LAST = 2'h2;
  localparam logic [3:0] DIGIT_MAX = 4'h9;
  // Line cycles per integration choice
  localparam logic [6:0] LINE_COUNT [6] = '{7'h01, 7'h05, 7'h0A, 7'h14, 7'h32, 7'h64};
  // Unit code [5:3] (0 uV,1 mV,2 V,3 mohm,4 ohm,5 kohm), integer digits [2:0]
  localparam logic [5:0] FMT_TABLE [4][5] = '{'{6'h0C, 6'h12, 6'h13, 6'h13, 6'h00},
                                             '{6'h04, 6'h0A, 6'h0B, 6'h0C, 6'h12},
                                             '{6'h1C, 6'h22, 6'h23, 6'h24, 6'h2A},
                                             '{6'h1B, 6'h1C, 6'h22, 6'h23, 6'h24}};
  typedef enum logic [1:0] {FN_DCV, FN_LOWDCV, FN_HIPR, FN_LOWPR} rsc_func_t;
  typedef enum logic [3:0] {PR_INT_TIME, PR_LINE, PR_RESOL, PR_BUZZER, PR_ANALOG, PR_COMPUTE,
                            PR_NULL, PR_SMOOTH, PR_CAL, PR_COUNT, PR_SMOOTHING_TIME_SETTING} rsc_param_t;
  typedef struct packed {
    logic auto_key, up_key, down_key, mode_key, trig_key, zero_key;
    logic home_key, ce_key, change_key, shift_key, enter_key;
    logic digit_v;
    logic [3:0] digit;
    logic param_v;
    rsc_param_t param_pri, param_alt;
    logic func_v;
    rsc_func_t func;
    logic init_cmd, power_on;
  } rsc_keys_t;
  typedef struct packed {
    logic valid, overload;
    logic [20:0] magnitude;
  } rsc_result_t;
  typedef struct packed {
    rsc_func_t func;
    logic auto_range;
    logic [2:0] range;
    logic hold, line60, auto_zero, compute, nul, smooth;
    logic [2:0] int_time;
    logic [1:0] buzzer, resolution;
    logic [2:0] analog;
    logic [11:0] cal, count, smoothing_time_setting;
  } rsc_settings_t;
  typedef struct packed {
    logic [2:0] unit, int_digits;
    logic [1:0] digits;
    logic overload;
    logic [20:0] reading;
  } rsc_display_t;
  localparam rsc_settings_t DEF_SET = '{func: FN_DCV, auto_range: 1'b1, range: 3'h1, hold: 1'b0,
    line60: 1'b0, auto_zero: 1'b1, compute: 1'b0, nul: 1'b0, smooth: 1'b0, int_time: 3'h1,
    buzzer: 2'h0, resolution: DIG_6, analog: 3'h0, cal: 12'h001, count: 12'h002, smoothing_time_setting: 12'h010};
endpackage

//--- logic/rsc_control.sv
/*
  Range, sampling and parameter entry control of the meter.
  Assumes synchronous one-cycle key and trigger pulses and an
  external converter that answers each start with one result.
*/
`timescale 1ns/1ps
module rsc_control #(
  parameter int LINE50_CYCLES = rsc_pkg::LINE50_CYC,
  parameter int LINE60_CYCLES = rsc_pkg::LINE60_CYC
) (
  input  wire logic                  I_CLK,
  input  wire logic                  I_RESET,
  input  wire rsc_pkg::rsc_keys_t    I_KEYS,
  input  wire logic                  I_REAR_TRIG,
  input  wire logic                  I_BUS_TRIG,
  input  wire rsc_pkg::rsc_result_t  I_RESULT,
  output logic                       O_SAMPLE_START,
  output logic                       O_BUSY,
  output rsc_pkg::rsc_settings_t     O_SETTINGS,
  output rsc_pkg::rsc_display_t      O_DISPLAY,
  output logic                       O_EDITING,
  output rsc_pkg::rsc_param_t        O_EDIT_PARAM,
  output logic [11:0]                O_EDIT_VALUE,
  output logic [1:0]                 O_CURSOR,
  output logic                       O_SHIFT
);
  typedef enum logic [1:0] {S_IDLE, S_INTEG, S_RESULT} rsc_samp_t;

  rsc_pkg::rsc_settings_t st_ff, nxt_st;
  rsc_pkg::rsc_display_t  disp_ff, nxt_disp;
  rsc_pkg::rsc_param_t    par_ff, nxt_par;
  logic                   edit_ff, nxt_edit;
  logic                   shift_ff, nxt_shift;
  logic [11:0]            buf_ff, nxt_buf;
  logic [1:0]             cur_ff, nxt_cur;
  rsc_samp_t              samp_ff, nxt_samp;
  logic [18:0]            cyc_ff, nxt_cyc;
  logic [7:0]             n_ff, nxt_n;
  logic                   start_ff, nxt_start;
  logic                   busy_ff, nxt_busy;
  logic                   take_res;
  logic                   trig_any;
  logic [18:0]            line_max;
  logic [7:0]             n_total;
  rsc_pkg::rsc_param_t    sel;

  function automatic logic [2:0] range_last(input rsc_pkg::rsc_func_t f);
    return (f == rsc_pkg::FN_DCV) ? rsc_pkg::RANGE_LAST_DCV : rsc_pkg::RANGE_LAST_OTH;
  endfunction

  // Digit class per range: low ohms and some edge ranges carry fewer digits
  function automatic logic [1:0] dig_class(input rsc_pkg::rsc_func_t f, input logic [2:0] r);
    if (f == rsc_pkg::FN_DCV) begin
      return rsc_pkg::DIG_6;
    end
    if (f == rsc_pkg::FN_LOWDCV) begin
      return (r == rsc_pkg::RANGE_LOW) ? rsc_pkg::DIG_5 : rsc_pkg::DIG_6;
    end
    if (f == rsc_pkg::FN_HIPR) begin
      return (r == rsc_pkg::RANGE_LAST_OTH) ? rsc_pkg::DIG_5 : rsc_pkg::DIG_6;
    end
    return (r == rsc_pkg::RANGE_LAST_OTH) ? rsc_pkg::DIG_4 : rsc_pkg::DIG_5;
  endfunction

  function automatic logic [20:0] up_level(input rsc_pkg::rsc_func_t f, input logic [2:0] r);
    logic [1:0] d;
    d = dig_class(f, r);
    if (f == rsc_pkg::FN_DCV && r == rsc_pkg::RANGE_LAST_DCV) begin
      return rsc_pkg::UP_TOP;
    end
    if (d == rsc_pkg::DIG_6) begin
      return rsc_pkg::UP_6D;
    end
    return (d == rsc_pkg::DIG_5) ? rsc_pkg::UP_5D : rsc_pkg::UP_4D;
  endfunction

  function automatic logic [20:0] down_level(input rsc_pkg::rsc_func_t f, input logic [2:0] r);
    logic [1:0] d;
    d = dig_class(f, r);
    if (f == rsc_pkg::FN_DCV && r == rsc_pkg::RANGE_LAST_DCV) begin
      return rsc_pkg::DN_TOP;
    end
    if (d == rsc_pkg::DIG_6) begin
      return rsc_pkg::DN_6D;
    end
    return (d == rsc_pkg::DIG_5) ? rsc_pkg::DN_5D : rsc_pkg::DN_4D;
  endfunction

  function automatic logic is_num(input rsc_pkg::rsc_param_t p);
    return p == rsc_pkg::PR_CAL || p == rsc_pkg::PR_COUNT || p == rsc_pkg::PR_SMOOTHING_TIME_SETTING;
  endfunction

  function automatic logic [11:0] wrap_inc(input logic [11:0] v, input logic [11:0] last);
    return (v >= last) ? 12'h000 : v + 12'h001;
  endfunction

  // Stored value of a parameter, widened into the edit buffer
  function automatic logic [11:0] get_val(input rsc_pkg::rsc_settings_t s,
                                          input rsc_pkg::rsc_param_t p);
    unique case (p)
      rsc_pkg::PR_INT_TIME: return {9'h000, s.int_time};
      rsc_pkg::PR_LINE:     return {11'h000, s.line60};
      rsc_pkg::PR_RESOL:    return {10'h000, s.resolution};
      rsc_pkg::PR_BUZZER:   return {10'h000, s.buzzer};
      rsc_pkg::PR_ANALOG:   return {9'h000, s.analog};
      rsc_pkg::PR_COMPUTE:  return {11'h000, s.compute};
      rsc_pkg::PR_NULL:     return {11'h000, s.nul};
      rsc_pkg::PR_SMOOTH:   return {11'h000, s.smooth};
      rsc_pkg::PR_CAL:      return s.cal;
      rsc_pkg::PR_COUNT:    return s.count;
      rsc_pkg::PR_SMOOTHING_TIME_SETTING:  return s.smoothing_time_setting;
      default:              return 12'h000;
    endcase
  endfunction

  // Commit; a one line cycle integration is refused off dc voltage
  function automatic rsc_pkg::rsc_settings_t put_val(input rsc_pkg::rsc_settings_t s,
                                                     input rsc_pkg::rsc_param_t p,
                                                     input logic [11:0] v);
    rsc_pkg::rsc_settings_t r;
    r = s;
    unique case (p)
      rsc_pkg::PR_INT_TIME: begin
        if (!(v[2:0] == rsc_pkg::INT_ONE && s.func != rsc_pkg::FN_DCV)) begin
          r.int_time = v[2:0];
        end
      end
      rsc_pkg::PR_LINE:    r.line60 = v[0];
      rsc_pkg::PR_RESOL:   r.resolution = v[1:0];
      rsc_pkg::PR_BUZZER:  r.buzzer = v[1:0];
      rsc_pkg::PR_ANALOG:  r.analog = v[2:0];
      rsc_pkg::PR_COMPUTE: r.compute = v[0];
      rsc_pkg::PR_NULL:    r.nul = v[0];
      rsc_pkg::PR_SMOOTH:  r.smooth = v[0];
      rsc_pkg::PR_CAL:     r.cal = v;
      rsc_pkg::PR_COUNT:   r.count = v;
      rsc_pkg::PR_SMOOTHING_TIME_SETTING: r.smoothing_time_setting = v;
      default:             r = s;
    endcase
    return r;
  endfunction

  assign trig_any = I_KEYS.trig_key | I_REAR_TRIG | I_BUS_TRIG;
  assign take_res = (samp_ff == S_RESULT) && I_RESULT.valid;
  assign sel      = shift_ff ? I_KEYS.param_alt : I_KEYS.param_pri;

  // Settings and edit state; key priority is init, function, range keys, auto range
  always_comb begin
    nxt_st    = st_ff;
    nxt_edit  = edit_ff;
    nxt_par   = par_ff;
    nxt_buf   = buf_ff;
    nxt_cur   = cur_ff;
    nxt_shift = shift_ff;
    if (I_KEYS.init_cmd) begin
      nxt_st        = rsc_pkg::DEF_SET;
      nxt_st.line60 = st_ff.line60;
      nxt_edit      = 1'b0;
      nxt_shift     = 1'b0;
    end else begin
      if (I_KEYS.power_on) begin
        nxt_st.compute = 1'b0;
        nxt_st.nul     = 1'b0;
        nxt_st.smooth  = 1'b0;
      end
      if (I_KEYS.func_v) begin
        nxt_st.func = I_KEYS.func;
        if (st_ff.range > range_last(I_KEYS.func)) begin
          nxt_st.range = range_last(I_KEYS.func);
        end
        if (I_KEYS.func != rsc_pkg::FN_DCV && st_ff.int_time == rsc_pkg::INT_ONE) begin
          nxt_st.int_time = rsc_pkg::DEF_SET.int_time;
        end
      end else if (I_KEYS.up_key || I_KEYS.down_key) begin
        nxt_st.auto_range = 1'b0;
        if (I_KEYS.up_key && !I_KEYS.down_key && st_ff.range < range_last(st_ff.func)) begin
          nxt_st.range = st_ff.range + 3'h1;
        end else if (I_KEYS.down_key && !I_KEYS.up_key && st_ff.range != rsc_pkg::RANGE_LOW) begin
          nxt_st.range = st_ff.range - 3'h1;
        end
      end else if (I_KEYS.auto_key) begin
        nxt_st.auto_range = !st_ff.auto_range;
      end else if (take_res && st_ff.auto_range) begin
        // Overload also climbs, so a saturated input finds its range
        if ((I_RESULT.overload || I_RESULT.magnitude >= up_level(st_ff.func, st_ff.range))
            && st_ff.range < range_last(st_ff.func)) begin
          nxt_st.range = st_ff.range + 3'h1;
        end else if (!I_RESULT.overload && st_ff.range != rsc_pkg::RANGE_LOW
                     && I_RESULT.magnitude <= down_level(st_ff.func, st_ff.range)) begin
          nxt_st.range = st_ff.range - 3'h1;
        end
      end
      if (I_KEYS.mode_key) begin
        nxt_st.hold = !st_ff.hold;
      end
      if (I_KEYS.zero_key) begin
        nxt_st.auto_zero = !st_ff.auto_zero;
      end
      if (edit_ff) begin
        if (I_KEYS.home_key) begin
          nxt_edit = 1'b0;
        end else if (I_KEYS.enter_key) begin
          nxt_st   = put_val(nxt_st, par_ff, buf_ff);
          nxt_edit = 1'b0;
        end else if (I_KEYS.ce_key) begin
          nxt_buf = 12'h000;
          nxt_cur = 2'h0;
        end else if (I_KEYS.shift_key) begin
          nxt_cur = (cur_ff >= rsc_pkg::CUR_LAST) ? 2'h0 : cur_ff + 2'h1;
        end else if (I_KEYS.change_key) begin
          unique case (par_ff)
            rsc_pkg::PR_INT_TIME: begin
              nxt_buf = wrap_inc(buf_ff, {9'h000, rsc_pkg::INT_LAST});
              if (nxt_buf[2:0] == rsc_pkg::INT_ONE && st_ff.func != rsc_pkg::FN_DCV) begin
                nxt_buf = wrap_inc(nxt_buf, {9'h000, rsc_pkg::INT_LAST});
              end
            end
            rsc_pkg::PR_RESOL:  nxt_buf = wrap_inc(buf_ff, rsc_pkg::RES_LAST);
            rsc_pkg::PR_BUZZER: nxt_buf = wrap_inc(buf_ff, rsc_pkg::BUZ_LAST);
            rsc_pkg::PR_ANALOG: nxt_buf = wrap_inc(buf_ff, rsc_pkg::ANA_LAST);
            rsc_pkg::PR_CAL, rsc_pkg::PR_COUNT, rsc_pkg::PR_SMOOTHING_TIME_SETTING: nxt_buf = buf_ff;
            default: nxt_buf = buf_ff ^ 12'h001;
          endcase
        end else if (I_KEYS.digit_v && is_num(par_ff) && I_KEYS.digit <= rsc_pkg::DIGIT_MAX) begin
          // Cursor 0 is the hundreds digit; entry walks rightward
          unique case (cur_ff)
            2'h0:    nxt_buf[11:8] = I_KEYS.digit;
            2'h1:    nxt_buf[7:4]  = I_KEYS.digit;
            default: nxt_buf[3:0]  = I_KEYS.digit;
          endcase
          nxt_cur = (cur_ff >= rsc_pkg::CUR_LAST) ? 2'h0 : cur_ff + 2'h1;
        end
      end else if (I_KEYS.shift_key) begin
        nxt_shift = !shift_ff;
      end
      if (I_KEYS.param_v) begin
        nxt_edit  = 1'b1;
        nxt_par   = sel;
        nxt_buf   = get_val(st_ff, sel);
        nxt_cur   = 2'h0;
        nxt_shift = 1'b0;
      end
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      st_ff    <= rsc_pkg::DEF_SET;
      edit_ff  <= 1'b0;
      par_ff   <= rsc_pkg::PR_INT_TIME;
      buf_ff   <= 12'h000;
      cur_ff   <= 2'h0;
      shift_ff <= 1'b0;
    end else begin
      st_ff    <= nxt_st;
      edit_ff  <= nxt_edit;
      par_ff   <= nxt_par;
      buf_ff   <= nxt_buf;
      cur_ff   <= nxt_cur;
      shift_ff <= nxt_shift;
    end
  end

  // Integration length: line cycles doubled when auto zero runs its own pass
  assign line_max = st_ff.line60 ? 19'(LINE60_CYCLES - 1) : 19'(LINE50_CYCLES - 1);
  assign n_total  = st_ff.auto_zero ? {rsc_pkg::LINE_COUNT[st_ff.int_time], 1'b0}
                                    : {1'b0, rsc_pkg::LINE_COUNT[st_ff.int_time]};

  // Sampler: triggers outside idle are ignored rather than queued
  always_comb begin
    nxt_samp  = samp_ff;
    nxt_cyc   = cyc_ff;
    nxt_n     = n_ff;
    nxt_start = 1'b0;
    nxt_disp  = disp_ff;
    nxt_disp.unit       = rsc_pkg::FMT_TABLE[st_ff.func][st_ff.range][5:3];
    nxt_disp.int_digits = rsc_pkg::FMT_TABLE[st_ff.func][st_ff.range][2:0];
    nxt_disp.digits     = dig_class(st_ff.func, st_ff.range);
    unique case (samp_ff)
      S_IDLE: begin
        if (!st_ff.hold || trig_any) begin
          nxt_samp  = S_INTEG;
          nxt_start = 1'b1;
          nxt_cyc   = 19'h00000;
          nxt_n     = 8'h00;
        end
      end
      S_INTEG: begin
        nxt_cyc = cyc_ff + 19'h00001;
        if (cyc_ff >= line_max) begin
          nxt_cyc = 19'h00000;
          nxt_n   = n_ff + 8'h01;
          if (n_ff + 8'h01 >= n_total) begin
            nxt_samp = S_RESULT;
          end
        end
      end
      S_RESULT: begin
        if (I_RESULT.valid) begin
          nxt_samp         = S_IDLE;
          nxt_disp.reading  = I_RESULT.magnitude;
          nxt_disp.overload = I_RESULT.overload;
        end
      end
      default: nxt_samp = S_IDLE;
    endcase
    nxt_busy = (nxt_samp != S_IDLE);
  end

  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      samp_ff  <= S_IDLE;
      cyc_ff   <= 19'h00000;
      n_ff     <= 8'h00;
      start_ff <= 1'b0;
      busy_ff  <= 1'b0;
      disp_ff  <= '0;
    end else begin
      samp_ff  <= nxt_samp;
      cyc_ff   <= nxt_cyc;
      n_ff     <= nxt_n;
      start_ff <= nxt_start;
      busy_ff  <= nxt_busy;
      disp_ff  <= nxt_disp;
    end
  end

  assign O_SAMPLE_START = start_ff;
  assign O_BUSY         = busy_ff;
  assign O_SETTINGS     = st_ff;
  assign O_DISPLAY      = disp_ff;
  assign O_EDITING      = edit_ff;
  assign O_EDIT_PARAM   = par_ff;
  assign O_EDIT_VALUE   = buf_ff;
  assign O_CURSOR       = cur_ff;
  assign O_SHIFT        = shift_ff;

  // Checks
  logic        quiet;
  logic [2:0]  cur_rng;
  logic [35:0] num_vals;
  assign quiet    = !I_KEYS.init_cmd && !I_KEYS.func_v;
  assign cur_rng  = st_ff.range;
  assign num_vals = {st_ff.cal, st_ff.count, st_ff.smoothing_time_setting};

  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RESET);

  auto_toggle_a: assert property (quiet && I_KEYS.auto_key && !I_KEYS.up_key && !I_KEYS.down_key
    |=> st_ff.auto_range != $past(st_ff.auto_range)) else $error("auto key did not toggle");
  range_up_a: assert property (quiet && !I_KEYS.up_key && !I_KEYS.down_key && !I_KEYS.auto_key
    && take_res && st_ff.auto_range && !I_RESULT.overload && cur_rng < range_last(st_ff.func)
    && I_RESULT.magnitude >= up_level(st_ff.func, cur_rng)
    |=> cur_rng == $past(cur_rng) + 3'h1) else $error("auto range did not climb");
  range_bound_a: assert property (cur_rng <= range_last(st_ff.func))
    else $error("range beyond function");
  manual_step_a: assert property (quiet && I_KEYS.up_key && !I_KEYS.down_key
    && cur_rng < range_last(st_ff.func) |=> cur_rng == $past(cur_rng) + 3'h1)
    else $error("up key step wrong");
  key_manual_a: assert property (quiet && (I_KEYS.up_key || I_KEYS.down_key) |=> !st_ff.auto_range)
    else $error("range key left auto on");
  run_repeat_a: assert property (samp_ff == S_IDLE && !st_ff.hold |=> start_ff && busy_ff)
    else $error("run mode did not restart");
  hold_wait_a: assert property (samp_ff == S_IDLE && st_ff.hold && !trig_any |=> !start_ff && !busy_ff)
    else $error("hold sampled without trigger");
  trig_start_a: assert property (samp_ff == S_IDLE && (I_REAR_TRIG || I_BUS_TRIG) |=> start_ff)
    else $error("trigger ignored in idle");
  mode_toggle_a: assert property (!I_KEYS.init_cmd && I_KEYS.mode_key |=> st_ff.hold != $past(st_ff.hold))
    else $error("mode key did not toggle");
  home_keep_a: assert property (edit_ff && I_KEYS.home_key && !I_KEYS.init_cmd && !I_KEYS.param_v
    |=> !edit_ff && num_vals == $past(num_vals)) else $error("home changed stored value");
  ce_clear_a: assert property (edit_ff && I_KEYS.ce_key && !I_KEYS.home_key && !I_KEYS.enter_key
    && !I_KEYS.param_v && !I_KEYS.init_cmd |=> buf_ff == 12'h000) else $error("entry not erased");
  commit_a: assert property (edit_ff && I_KEYS.enter_key && !I_KEYS.home_key && !I_KEYS.init_cmd
    && par_ff == rsc_pkg::PR_SMOOTHING_TIME_SETTING |=> st_ff.smoothing_time_setting == $past(buf_ff)) else $error("enter lost value");
  power_on_a: assert property (I_KEYS.power_on && !I_KEYS.init_cmd && !edit_ff
    |=> !st_ff.compute && !st_ff.nul && !st_ff.smooth) else $error("power-on left options on");
  init_a: assert property (I_KEYS.init_cmd |=> st_ff.auto_range && cur_rng == rsc_pkg::DEF_SET.range
    && !st_ff.hold && st_ff.line60 == $past(st_ff.line60)) else $error("init defaults wrong");
  one_cyc_a: assert property (st_ff.func != rsc_pkg::FN_DCV |-> st_ff.int_time != rsc_pkg::INT_ONE)
    else $error("one line cycle off dc");

  run_sample_c: cover property (start_ff ##[1:1000] take_res);
  hold_trig_c:  cover property (st_ff.hold && samp_ff == S_IDLE && I_BUS_TRIG ##1 start_ff);
  autorange_c:  cover property (take_res && st_ff.auto_range ##1 $changed(cur_rng));
  commit_c:     cover property (edit_ff && I_KEYS.enter_key);
endmodule

//--- test/rsc_conv_model.sv
/*
  Converter stand-in that answers each sample start with one result.
  Assumes one shared clock and a start pulse of one cycle.
*/
`timescale 1ns/1ps
module rsc_conv_model #(
  parameter int LAT = 3
) (
  input  wire logic            i_clk,
  input  wire logic            i_start,
  input  wire logic            i_busy,
  input  wire logic [20:0]     i_mag,
  output rsc_pkg::rsc_result_t o_res
);
  int cnt_ff = 0;
  // Cycles since the last start
  always @(posedge i_clk) cnt_ff <= i_start ? 0 : cnt_ff + 1;
  // Valid holds until the result is taken, so a slow sampler still sees it
  always_comb begin
    o_res.valid     = i_busy && !i_start && cnt_ff >= LAT;
    o_res.overload  = 1'b0;
    o_res.magnitude = o_res.valid ? i_mag : ~i_mag; // Stale data never looks right
  end
endmodule

//--- test/tb.sv
/*
  Self-checking bench for the range and sampling control.
  Assumes the converter model beside it and short line-cycle counts.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fail_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module tb;
  logic                   clk = 0, rst = 1, rear = 0, bus = 0, start, bsy, edt;
  logic [20:0]            mag = 21'h100000;
  logic [11:0]            ev;
  rsc_pkg::rsc_keys_t     keys = '0, k;
  rsc_pkg::rsc_result_t   res;
  rsc_pkg::rsc_settings_t st;
  rsc_pkg::rsc_display_t  dsp;
  logic                   sh;
  int                     fail_count = 0, n_tests = 0, starts = 0, n;
  localparam logic [20:0] MG [7] = '{rsc_pkg::UP_6D, rsc_pkg::UP_6D, 21'h07EF3F, rsc_pkg::DN_TOP,
                                     rsc_pkg::DN_6D, 21'h000000, 21'h000000};
  localparam logic [2:0]  RG [7] = '{3'h2, 3'h3, 3'h3, 3'h2, 3'h1, 3'h0, 3'h0};
  // Clock and start counter
  always #20 clk = ~clk;
  always @(posedge clk) if (start === 1'b1) starts++;
  rsc_control #(.LINE50_CYCLES(4), .LINE60_CYCLES(3)) i_dut (.I_CLK(clk), .I_RESET(rst), .I_KEYS(keys),
    .I_REAR_TRIG(rear), .I_BUS_TRIG(bus), .I_RESULT(res), .O_SAMPLE_START(start), .O_BUSY(bsy),
    .O_SETTINGS(st), .O_DISPLAY(dsp), .O_EDITING(edt), .O_EDIT_PARAM(), .O_EDIT_VALUE(ev), .O_CURSOR(),
    .O_SHIFT(sh));
  rsc_conv_model #(.LAT(3)) i_conv (.i_clk(clk), .i_start(start), .i_busy(bsy), .i_mag(mag), .o_res(res));
  // One key pulse; bit index counted from the top of the key struct
  function automatic rsc_pkg::rsc_keys_t kb(input int i);
    kb = '0;
    kb[$bits(kb) - 1 - i] = 1'b1;
  endfunction
  task automatic kp(input rsc_pkg::rsc_keys_t v, input logic r = 0, input logic b = 0);
    @(posedge clk);
    keys <= v;
    rear <= r;
    bus <= b;
    @(posedge clk);
    keys <= '0;
    rear <= 1'b0;
    bus <= 1'b0;
    @(negedge clk);
  endtask
  task automatic wait_done;
    for (int i = 0; i < 300 && bsy !== 1'b1; i++) @(negedge clk);
    for (int i = 0; i < 300 && bsy !== 1'b0; i++) @(negedge clk);
  endtask
  task automatic open_p(input rsc_pkg::rsc_param_t p);
    k = kb(16);
    k.param_pri = p;
    kp(k);
  endtask
  task automatic dig3;
    k = kb(11);
    k.digit = 4'h3;
    kp(k);
  endtask
  task automatic t_auto;
    for (int i = 0; i < 7; i++) begin
      mag = MG[i];
      wait_done;
      `CHK(st.range, RG[i])
      `CHK(dsp.reading, MG[i])
    end
    // Lowest dc range: millivolts, four integer digits, full resolution
    @(negedge clk);
    `CHK({dsp.unit, dsp.int_digits, dsp.digits}, 8'h30)
  endtask
  task automatic t_misc;
    kp(kb(9));
    `CHK(sh, 1'b1)
    k = kb(16);
    k.param_pri = rsc_pkg::PR_CAL;
    k.param_alt = rsc_pkg::PR_LINE;
    kp(k);
    `CHK({sh, ev}, 13'h0000)
    kp(kb(8));
    kp(kb(10));
    `CHK(st.line60, 1'b1)
    // Busy spans ten line cycles of three clocks plus the result cycle
    for (int i = 0; i < 300 && bsy !== 1'b0; i++) @(negedge clk);
    for (int i = 0; i < 300 && bsy !== 1'b1; i++) @(negedge clk);
    n = 0;
    while (bsy === 1'b1 && n < 300) begin
      n++;
      @(negedge clk);
    end
    `CHK(n, 31)
    open_p(rsc_pkg::PR_COMPUTE);
    kp(kb(8));
    kp(kb(10));
    `CHK(st.compute, 1'b1)
    kp(kb(29));
    `CHK(st.compute, 1'b0)
    open_p(rsc_pkg::PR_BUZZER);
    dig3;
    `CHK(ev, 12'h000)
    kp(kb(6));
  endtask
  task automatic t_manual;
    kp(kb(0));
    `CHK(st.auto_range, 1'b0)
    kp(kb(0));
    `CHK(st.auto_range, 1'b1)
    kp(kb(1));
    `CHK({st.auto_range, st.range}, 4'h1)
    kp(kb(1));
    `CHK(st.range, 3'h2)
    kp(kb(2));
    `CHK(st.range, 3'h1)
  endtask
  task automatic t_hold;
    kp(kb(3));
    `CHK(st.hold, 1'b1)
    repeat (100) @(negedge clk);
    n = starts;
    repeat (100) @(negedge clk);
    `CHK(starts, n)
    for (int s = 0; s < 3; s++) begin
      kp(s == 0 ? kb(4) : '0, s == 1, s == 2);
      repeat (100) @(negedge clk);
      `CHK(starts, n + s + 1)
    end
    kp(kb(3));
    repeat (100) @(negedge clk);
    `CHK({st.hold, starts > n + 4}, 2'h1)
  endtask
  task automatic t_edit;
    open_p(rsc_pkg::PR_SMOOTHING_TIME_SETTING);
    `CHK({edt, ev}, 13'h1010)
    dig3;
    `CHK(ev, 12'h310)
    kp(kb(6));
    `CHK({edt, st.smoothing_time_setting}, 13'h0010)
    open_p(rsc_pkg::PR_SMOOTHING_TIME_SETTING);
    dig3;
    kp(kb(7));
    `CHK(ev, 12'h000)
    open_p(rsc_pkg::PR_SMOOTHING_TIME_SETTING);
    dig3;
    kp(kb(10));
    `CHK({edt, st.smoothing_time_setting}, 13'h0310)
  endtask
  task automatic t_int;
    open_p(rsc_pkg::PR_INT_TIME);
    kp(kb(8));
    kp(kb(10));
    `CHK(st.int_time, 3'h2)
    open_p(rsc_pkg::PR_INT_TIME);
    repeat (4) kp(kb(8));
    kp(kb(10));
    `CHK(st.int_time, 3'h0)
    k = kb(25);
    k.func = rsc_pkg::FN_LOWDCV;
    kp(k);
    `CHK(st.int_time, 3'h1)
    kp(kb(28));
    `CHK(st, rsc_pkg::DEF_SET)
  endtask
  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Watchdog well beyond the expected thousand or so cycles
  initial begin
    #(20000 * 40);
    fail_count++;
    print_verdict;
  end
  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    `CHK(st, rsc_pkg::DEF_SET)
    t_auto;
    t_manual;
    t_hold;
    t_edit;
    t_int;
    t_misc;
    print_verdict;
  end
endmodule
